/* common/osp_pkg.sv */
// osp_pkg: constants, timing counts, register map and carrier types for
// the static programming controller of a one-time-programmable rom.
// assumes a 20 MHz system clock; all pin timing is counted in its cycles.
package osp_pkg;

  // ---------------------------------------------------------------
  // clock and device timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ   = 20;
  localparam int T_VS_NS   = 2000;   // supply setup before first pulse
  localparam int T_AS_NS   = 100;    // address setup
  localparam int T_DS_NS   = 100;    // data setup
  localparam int T_AH_NS   = 2000;   // address hold after pulse
  localparam int T_PW_NS   = 10000;  // program pulse, typical width
  localparam int T_OES_NS  = 2000;   // output gate setup
  localparam int T_ACC_NS  = 80;     // access time, longest
  // least times round up to whole cycles
  localparam int CYC_VS    = (T_VS_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_AS    = (T_AS_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_DS    = (T_DS_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_AH    = (T_AH_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_PW    = (T_PW_NS * CLK_MHZ) / 1000;
  localparam int CYC_OES   = (T_OES_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_ACC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_SETUP = (CYC_AS > CYC_DS) ? CYC_AS : CYC_DS;
  localparam int CNT_W     = 8;

  // ---------------------------------------------------------------
  // pin widths
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 21;
  localparam int LOW_W   = 8;
  localparam int HIGH_W  = ADDR_W - LOW_W;
  localparam int DATA_W  = 16;

  // ---------------------------------------------------------------
  // contact check codes
  // ---------------------------------------------------------------
  localparam logic [HIGH_W-1:0] CC_HI_A  = 13'h16AA;
  localparam logic [LOW_W-1:0]  CC_LO_A  = 8'hAA;
  localparam logic [DATA_W-1:0] CC_DQ_A  = 16'hAAAA;
  localparam logic [HIGH_W-1:0] CC_HI_B  = 13'h0955;
  localparam logic [LOW_W-1:0]  CC_LO_B  = 8'h55;
  localparam logic [DATA_W-1:0] CC_DQ_B  = 16'h5555;
  localparam logic [HIGH_W-1:0] CC_HI_X  = 13'h0000;
  localparam logic [LOW_W-1:0]  CC_LO_X  = 8'h00;
  localparam logic [DATA_W-1:0] CC_DQ_X  = 16'hFFFF;

  // ---------------------------------------------------------------
  // register map (byte offsets) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_STATIC = 3;
  localparam int STS_BUSY    = 0;
  localparam int STS_DONE    = 1;
  localparam int STS_MATCH   = 2;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OSP_OP_PROG, OSP_OP_VERIFY, OSP_OP_READ, OSP_OP_CHECK} osp_op_e;

  typedef struct packed {
    logic              start;
    osp_op_e           op;
    logic              static_sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } osp_cmd_s;

  typedef struct packed {
    logic              busy;
    logic              done;
    logic              match;
    logic [DATA_W-1:0] rdata;
  } osp_sts_s;

  typedef struct packed {
    logic              static_mode_select;
    logic              addr_mux_select;
    logic              chip_sel_n;
    logic              out_gate_n;
    logic              out_gate_check;
    logic              vpp_prog;
    logic [HIGH_W-1:0] high_address_pins;
    logic [LOW_W-1:0]  low_address_pins;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
  } osp_pins_s;

endpackage

/* design/osp_apb_regs.sv */
// osp_apb_regs: apb slave holding the controller's command word and reading back its status.
// assumes apb3 signalling on clk_i; answers with one wait state.
`timescale 1ns/1ns
module osp_apb_regs
  import osp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output osp_cmd_s         cmd_o,
  input  wire osp_sts_s    sts_i
);

  logic access;
  logic known;

  // access phase seen, answer given on the following edge
  assign access = psel_i & penable_i & ~pready_o;
  assign known  = (paddr_i == OFS_CTRL) || (paddr_i == OFS_ADDR) || (paddr_i == OFS_WDATA)
               || (paddr_i == OFS_STATUS) || (paddr_i == OFS_RDATA);

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= access;
      pslverr_o <= access & ~known;   // unmapped address is an error
      prdata_o  <= 32'h0000_0000;
      if (access && !pwrite_i)
      begin
        if (paddr_i == OFS_CTRL)
          prdata_o <= {28'h0000000, cmd_o.static_sel, cmd_o.op, 1'b0};
        else if (paddr_i == OFS_ADDR)
          prdata_o <= {11'h000, cmd_o.addr};
        else if (paddr_i == OFS_WDATA)
          prdata_o <= {16'h0000, cmd_o.wdata};
        else if (paddr_i == OFS_STATUS)
          prdata_o <= {29'h00000000, sts_i.match, sts_i.done, sts_i.busy};
        else if (paddr_i == OFS_RDATA)
          prdata_o <= {16'h0000, sts_i.rdata};
      end
    end
  end

  // ---------------------------------------------------------------
  // command registers; start is a one-cycle pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cmd_o <= '0;
    end
    else
    begin
      cmd_o.start <= 1'b0;
      if (access && pwrite_i)
      begin
        if (paddr_i == OFS_CTRL)
        begin
          cmd_o.start      <= pwdata_i[CTRL_START];
          cmd_o.op         <= osp_op_e'(pwdata_i[CTRL_OP_LSB +: 2]);
          cmd_o.static_sel <= pwdata_i[CTRL_STATIC];
        end
        else if (paddr_i == OFS_ADDR)
          cmd_o.addr <= pwdata_i[ADDR_W-1:0];
        else if (paddr_i == OFS_WDATA)
          cmd_o.wdata <= pwdata_i[DATA_W-1:0];
      end
    end
  end

endmodule

/* design/osp_prog_ctrl.sv */
// osp_prog_ctrl: programmer-side controller for the static programming
// port of an otp rom: program, verify, read and contact check of one word.
// assumes the rom pins are wired to pins_o/dq_i through level shifters that
// turn vpp_prog into the programming supply and out_gate_check into the
// distinctive high gate voltage; dq_i is synchronous to clk_i.
`timescale 1ns/1ns

// Behaviour
// - program a word with chip select low, gate high, one 10 us pulse.
// - with programming supply high, change address only while chip select is high.
// - verify: chip select and gate low, device drives stored word for comparison.
// - keep program and verify as separate passes, seconds apart; the controller leaves the spacing to software.
// - one program pulse per word; program words consecutively.
// - chip select low plus high gate voltage enters contact check mode.
// - contact check order: power, chip select low, raise gate, apply codes; the first code is applied on the same edge as the gate.
module osp_prog_ctrl
  import osp_pkg::*;
#(
  parameter int ADDR_BITS = 21,
  parameter int DATA_BITS = 16
)
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output osp_pins_s        pins_o,
  input  wire logic [15:0] dq_i
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W)
  begin : g_bad_width
    $error("pin widths must match the package carrier types");
  end
  if (CYC_PW >= (1 << CNT_W) || CYC_OES + CYC_VS >= (1 << CNT_W))
  begin : g_bad_count
    $error("timing counter too narrow");
  end

  typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_GATE, ST_SENSE, ST_DONE} osp_state_e;

  osp_state_e        state;
  osp_cmd_s          cmd;
  osp_sts_s          sts;
  osp_op_e           op;
  logic [CNT_W-1:0]  cnt;
  logic [1:0]        probe;
  logic              cnt_zero;
  logic [DATA_W-1:0] expect_dq;

  assign cnt_zero = (cnt == '0);

  // ---------------------------------------------------------------
  // register slave
  // ---------------------------------------------------------------
  osp_apb_regs u_regs (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .cmd_o     (cmd),
    .sts_i     (sts)
  );

  // expected word for the current sense step
  always_comb
  begin
    expect_dq = cmd.wdata;
    if (op == OSP_OP_CHECK)
    begin
      if (probe == 2'd0)
        expect_dq = CC_DQ_A;
      else if (probe == 2'd1)
        expect_dq = CC_DQ_B;
      else
        expect_dq = CC_DQ_X;
    end
  end

  // ---------------------------------------------------------------
  // pin sequencer: state, timer and all pin levels
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state                     <= ST_IDLE;
      op                        <= OSP_OP_PROG;
      cnt                       <= '0;
      probe                     <= 2'd0;
      pins_o                    <= '0;
      pins_o.static_mode_select <= 1'b0;
      pins_o.chip_sel_n         <= 1'b1;
      pins_o.out_gate_n         <= 1'b1;
      pins_o.dq_oe_n            <= 1'b1;
    end
    else
    begin
      if (!cnt_zero)
        cnt <= cnt - 1'b1;
      // mux select held low; device also pulls it down
      pins_o.addr_mux_select <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          pins_o.static_mode_select <= cmd.static_sel;
          if (cmd.start && cmd.static_sel)
          begin
            op    <= cmd.op;
            probe <= 2'd0;
            state <= ST_SETUP;
            // address moves only while chip select is high
            pins_o.chip_sel_n        <= 1'b1;
            pins_o.out_gate_n        <= 1'b1;
            pins_o.high_address_pins <= cmd.addr[ADDR_W-1:LOW_W];
            pins_o.low_address_pins  <= cmd.addr[LOW_W-1:0];
            pins_o.dq_out            <= cmd.wdata;
            pins_o.dq_oe_n           <= (cmd.op != OSP_OP_PROG);
            // supply raised for program and verify only
            pins_o.vpp_prog <= (cmd.op == OSP_OP_PROG) || (cmd.op == OSP_OP_VERIFY);
            if (cmd.op == OSP_OP_PROG)
              cnt <= CNT_W'(CYC_VS + CYC_SETUP);
            else if (cmd.op == OSP_OP_VERIFY)
              cnt <= CNT_W'(CYC_VS + CYC_OES);
            else
              cnt <= CNT_W'(CYC_SETUP);
          end
        end
        ST_SETUP:
        begin
          if (cnt_zero)
          begin
            pins_o.chip_sel_n <= 1'b0;
            if (op == OSP_OP_PROG)
            begin
              // single pulse of typical width, gate high
              cnt   <= CNT_W'(CYC_PW);
              state <= ST_PULSE;
            end
            else if (op == OSP_OP_CHECK)
            begin
              // chip select low first, gate raised next
              cnt   <= CNT_W'(CYC_SETUP);
              state <= ST_GATE;
            end
            else
            begin
              // gate low so the device drives the word
              pins_o.out_gate_n <= 1'b0;
              cnt               <= CNT_W'(CYC_ACC + 1);
              state             <= ST_SENSE;
            end
          end
        end
        ST_PULSE:
        begin
          if (cnt_zero)
          begin
            // exactly one pulse, then back to inhibit
            pins_o.chip_sel_n <= 1'b1;
            cnt               <= CNT_W'(CYC_AH);
            state             <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // address and data still held for the hold time
          if (cnt_zero)
            state <= ST_DONE;
        end
        ST_GATE:
        begin
          if (cnt_zero)
          begin
            // high gate voltage with chip select low
            pins_o.out_gate_check    <= 1'b1;
            pins_o.high_address_pins <= CC_HI_A;
            pins_o.low_address_pins  <= CC_LO_A;
            cnt                      <= CNT_W'(CYC_OES + CYC_ACC);
            state                    <= ST_SENSE;
          end
        end
        ST_SENSE:
        begin
          if (cnt_zero)
          begin
            if (op == OSP_OP_CHECK && probe != 2'd2)
            begin
              // next check code, chip select stays low
              probe <= probe + 2'd1;
              cnt   <= CNT_W'(CYC_ACC + 1);
              if (probe == 2'd0)
              begin
                pins_o.high_address_pins <= CC_HI_B;
                pins_o.low_address_pins  <= CC_LO_B;
              end
              else
              begin
                pins_o.high_address_pins <= CC_HI_X;
                pins_o.low_address_pins  <= CC_LO_X;
              end
            end
            else
              state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // release data drive, deselect, drop gate and supply; address stays driven; device floats its outputs
          pins_o.chip_sel_n     <= 1'b1;
          pins_o.out_gate_n     <= 1'b1;
          pins_o.out_gate_check <= 1'b0;
          pins_o.vpp_prog       <= 1'b0;
          pins_o.dq_oe_n        <= 1'b1;
          state                 <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status: busy, sticky done, match and captured word
  // ---------------------------------------------------------------
  // verify is its own command; software spaces it from program
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sts <= '0;
    end
    else
    begin
      if (state == ST_IDLE && cmd.start && cmd.static_sel)
      begin
        sts.busy  <= 1'b1;
        sts.done  <= 1'b0;
        sts.match <= 1'b1;
      end
      else if (state == ST_DONE)
      begin
        sts.busy <= 1'b0;
        sts.done <= 1'b1;
      end
      if (state == ST_SENSE && cnt_zero)
      begin
        sts.rdata <= dq_i;
        // read only captures; verify and check compare
        if (op != OSP_OP_READ && dq_i != expect_dq)
          sts.match <= 1'b0;
      end
    end
  end

endmodule

/* testbench/osp_prog_monitor.sv */
// osp_prog_monitor: pin and bus assertions for the static programming controller.
// assumes it is bound into osp_prog_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module osp_prog_monitor
  import osp_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      sys_rst_i,
  input  wire logic      psel_i,
  input  wire logic      penable_i,
  input  wire logic      pready_o,
  input  wire logic      pslverr_o,
  input  wire osp_pins_s pins_o
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic       prog_lvl;
  logic [7:0] low_cnt;
  logic [7:0] vpp_cnt;
  logic [1:0] pulses;
  assign prog_lvl = !pins_o.chip_sel_n && pins_o.out_gate_n && pins_o.vpp_prog;
  // length of the current program pulse
  always_ff @(posedge clk_i)
  begin
    low_cnt <= (prog_lvl && !sys_rst_i) ? low_cnt + 8'h01 : 8'h00;
  end
  // supply time, saturating so a long session cannot wrap
  always_ff @(posedge clk_i)
  begin
    vpp_cnt <= (!pins_o.vpp_prog || sys_rst_i) ? 8'h00 :
               (vpp_cnt == 8'hFF) ? vpp_cnt : vpp_cnt + 8'h01;
  end
  // pulses seen in one supply session
  always_ff @(posedge clk_i)
  begin
    pulses <= (!pins_o.vpp_prog || sys_rst_i) ? 2'd0 :
              pulses + {1'b0, prog_lvl && low_cnt == 8'h00 && pulses != 2'd3};
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_pulse_width: assert property ($rose(pins_o.chip_sel_n) && low_cnt != 8'h00 |->
    low_cnt >= 8'd180 && low_cnt <= 8'd220) else $error("program pulse width off");
  a_drive_prog: assert property (!pins_o.dq_oe_n |-> pins_o.vpp_prog &&
    pins_o.out_gate_n && !pins_o.out_gate_check) else $error("data driven outside program");
  a_supply_setup: assert property ($rose(prog_lvl) |-> vpp_cnt >= CYC_VS)
    else $error("pulse before supply settled");
  a_addr_inhibit: assert property (pins_o.vpp_prog &&
    $changed({pins_o.high_address_pins, pins_o.low_address_pins}) |->
    pins_o.chip_sel_n && $past(pins_o.chip_sel_n)) else $error("address moved outside inhibit");
  a_verify_float: assert property (!pins_o.chip_sel_n && !pins_o.out_gate_n |->
    pins_o.dq_oe_n) else $error("controller drives data during verify");
  a_verify_apart: assert property (!pins_o.out_gate_n && pins_o.vpp_prog |->
    pulses == 2'd0) else $error("verify in same pass as program");
  a_one_pulse: assert property (pulses < 2'd2)
    else $error("more than one pulse per word");
  a_check_order: assert property ($rose(pins_o.out_gate_check) |->
    $past(pins_o.chip_sel_n) == 1'b0 && pins_o.static_mode_select && !pins_o.vpp_prog)
    else $error("check gate raised out of order");
  a_static_sel: assert property (!pins_o.chip_sel_n |-> pins_o.static_mode_select)
    else $error("chip select without static mode");
  a_mux_low: assert property (!pins_o.addr_mux_select)
    else $error("mux select not low");
  a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb answer not one wait state");

  cover property (prog_lvl && low_cnt == 8'd1);
  cover property (!pins_o.out_gate_n && pins_o.vpp_prog);
  cover property ($rose(pins_o.out_gate_check));
  cover property (pready_o && pslverr_o);
endmodule

bind osp_prog_ctrl osp_prog_monitor u_mon (
  .clk_i     (clk_i),
  .sys_rst_i (sys_rst_i),
  .psel_i    (psel_i),
  .penable_i (penable_i),
  .pready_o  (pready_o),
  .pslverr_o (pslverr_o),
  .pins_o    (pins_o)
);

/* testbench/osp_rom_model.sv */
// osp_rom_model: behavioural otp rom seen through its static programming pins.
// assumes pins come registered on clk_i; answers one cycle later on dq_o.
`timescale 1ns/1ns
module osp_rom_model
  import osp_pkg::*;
(
  input  wire logic      clk_i,
  input  wire osp_pins_s pins_i,
  input  wire logic      bad_i,
  output logic [15:0]    dq_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] addr;
  assign addr = {pins_i.high_address_pins, pins_i.low_address_pins};
  initial dq_o = 16'h0000;

  // erased cells read as ones
  function automatic logic [DATA_W-1:0] stored(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  always @(posedge clk_i)
  begin
    if (pins_i.static_mode_select && pins_i.vpp_prog && !pins_i.chip_sel_n &&
        pins_i.out_gate_n && !pins_i.out_gate_check)
      mem[addr] = stored(addr) & pins_i.dq_out;
  end

  // output select
  // mux select is ignored: the pin is pulled low in static mode
  // a floating bus toggles so a stale value never looks valid
  always @(posedge clk_i)
  begin
    if (!pins_i.static_mode_select || pins_i.chip_sel_n)
      dq_o <= ~dq_o;
    else if (pins_i.out_gate_check)
      dq_o <= {15'h0000, bad_i} ^
        ((pins_i.high_address_pins == CC_HI_A && pins_i.low_address_pins == CC_LO_A) ? CC_DQ_A :
         (pins_i.high_address_pins == CC_HI_B && pins_i.low_address_pins == CC_LO_B) ? CC_DQ_B :
         16'hFFFF);
    else if (!pins_i.out_gate_n)
      dq_o <= stored(addr);
    else
      dq_o <= ~dq_o;
  end
endmodule

/* testbench/test_otp_static_program_port.sv */
// test_otp_static_program_port: self-checking bench for osp_prog_ctrl.
// assumes the rom model on the far side and apb stimulus from the tasks here.
`timescale 1ns/1ns
module test_otp_static_program_port
  import osp_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  osp_pins_s   pins_o;
  logic [15:0] dq_i;
  logic        bad = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          num_checks = 0;

  initial forever #25 clk_i = ~clk_i;

  osp_prog_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pins_o(pins_o),
    .dq_i(dq_i));
  osp_rom_model u_rom (.clk_i(clk_i), .pins_i(pins_o), .bad_i(bad), .dq_o(dq_i));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high.
  // the answer is looked at mid-cycle, where it is settled, so reading it
  // never races the edge that launches or drops it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(negedge clk_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    rd = prdata_o;
    err = pslverr_o;
    // completion edge: pready is sampled high here, only then release
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      test_done;
    end
  endtask

  // poll status until done, bounded
  task automatic wait_done;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[STS_DONE] !== 1'b1 && n < 200)
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      test_done;
    end
  endtask

  task automatic run_op(input osp_op_e op, input logic [20:0] a, input logic [15:0] d);
    apb(1'b1, OFS_ADDR, {11'h000, a});
    apb(1'b1, OFS_WDATA, {16'h0000, d});
    apb(1'b1, OFS_CTRL, {28'h0, 1'b1, op, 1'b1});
    wait_done;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_regs;
    chk({pins_o.vpp_prog, pins_o.chip_sel_n, pins_o.out_gate_n, pins_o.dq_oe_n}, 4'b0111, "rst");
    apb(1'b1, OFS_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, OFS_ADDR, 32'h0);
    chk(rd, 32'h001F_FFFF, "addr field");
    apb(1'b1, 8'h20, 32'h0);
    chk(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STS_BUSY], 1'b0, "start without static");
    chk({pins_o.static_mode_select, pins_o.chip_sel_n}, 2'b01, "static pin");
  endtask

  // two words back to back, boundary addresses; a start while busy is refused
  task automatic t_program;
    run_op(OSP_OP_PROG, 21'h00000, 16'hA5C3);
    apb(1'b1, OFS_ADDR, 32'h001F_FFFF);
    apb(1'b1, OFS_WDATA, 32'h0000_3C5A);
    apb(1'b1, OFS_CTRL, 32'h0000_0009);
    apb(1'b1, OFS_CTRL, 32'h0000_000D);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STS_BUSY], 1'b1, "busy during program");
    wait_done;
    // refused start still stores op and static bit; start reads back 0
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_000C, "ctrl readback");
  endtask

  task automatic t_verify;
    run_op(OSP_OP_VERIFY, 21'h00000, 16'hA5C3);
    chk(rd[STS_MATCH], 1'b1, "verify match");
    run_op(OSP_OP_VERIFY, 21'h1FFFFF, 16'hFFFF);
    chk(rd[STS_MATCH], 1'b0, "verify miss");
  endtask

  task automatic t_read;
    run_op(OSP_OP_READ, 21'h1FFFFF, 16'h0000);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h0000_3C5A, "read word");
    run_op(OSP_OP_READ, 21'h00001, 16'h0000);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h0000_FFFF, "read erased");
  endtask

  task automatic t_check;
    run_op(OSP_OP_CHECK, 21'h00000, 16'h0000);
    chk(rd[STS_MATCH], 1'b1, "contact good");
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h0000_FFFF, "last probe");
    bad <= 1'b1;
    run_op(OSP_OP_CHECK, 21'h00000, 16'h0000);
    chk(rd[STS_MATCH], 1'b0, "contact bad");
    bad <= 1'b0;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_regs;
    t_program;
    t_verify;
    t_read;
    t_check;
    test_done;
  end
endmodule
